// ==== logic/idt_core.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "idt_consts.svh"

module idt_core (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Program memory side
  input wire logic [`IDT_WORD_W-1:0] INSTR_WORD,
  input wire logic [1:0] PTR_PROG,
  output var logic FETCH_STB,
  // Cycle timing
  output var logic [1:0] PHASE,
  output var logic CYCLE_START,
  output var logic EXTRA_CYCLE,
  output var logic FLUSH_CYCLE,
  output var logic [1:0] INSN_CYCLES,
  // Decoded instruction
  output var logic EXEC_VALID,
  output var idt_pkg::idt_class_type INSN_CLASS,
  output var logic [`IDT_FILE_W-1:0] FILE_ADDR,
  output var logic [2:0] BIT_SEL,
  output var logic [`IDT_LIT_W-1:0] LITERAL,
  output var logic PTR_SEL,
  output var idt_pkg::idt_step_type PTR_STEP,
  output var logic DEST_ACCUM,
  // Register file and accumulator strobes
  output var logic RD_FILE,
  output var logic WR_FILE,
  output var logic WR_ACCUM
);
  import idt_pkg::*;

  idt_class_type dec_cls;
  logic [`IDT_FILE_W-1:0] dec_file;
  logic [2:0] dec_bit;
  logic [`IDT_LIT_W-1:0] dec_lit;
  logic dec_ptr;
  idt_step_type dec_step;
  logic dec_fop;
  logic dec_acc;
  logic dec_wf;
  logic dec_two;
  logic dec_ind;

  idt_state_type state_r, state_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic valid_r, valid_nxt;
  logic two_r, two_nxt;
  logic ind_r, ind_nxt;
  logic fop_r, fop_nxt;
  logic wf_r, wf_nxt;
  logic fetch_r, fetch_nxt;
  logic cyc_r, cyc_nxt;
  logic rd_r, rd_nxt;
  logic wr_file_r, wr_file_nxt;
  logic wr_acc_r, wr_acc_nxt;
  logic [1:0] ncyc_r, ncyc_nxt;
  idt_class_type cls_r, cls_nxt;
  logic [`IDT_FILE_W-1:0] file_r, file_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [`IDT_LIT_W-1:0] lit_r, lit_nxt;
  logic ptr_r, ptr_nxt;
  idt_step_type step_r, step_nxt;
  logic acc_r, acc_nxt;
  logic extra_r, extra_nxt;
  logic flush_r, flush_nxt;
  logic q_end;
  logic take;
  logic exec;
  logic ind_hit;

  idt_field_extract u_extract (
    .word(INSTR_WORD),
    .cls(dec_cls),
    .file_addr(dec_file),
    .bit_sel(dec_bit),
    .literal(dec_lit),
    .ptr_sel(dec_ptr),
    .ptr_step_sel(dec_step),
    .file_op(dec_fop),
    .dest_accum(dec_acc),
    .writes_file(dec_wf),
    .two_cycle(dec_two),
    .indirect(dec_ind)
  );

  always_comb begin
    ph_nxt = ph_r + 2'h1;
    q_end = ph_r == `IDT_PH_LAST;
    ind_hit = dec_ind & PTR_PROG[dec_ptr];
    // The word in the pipe is only held back behind an indirect stall
    take = !(state_r == IDT_ST_RUN && valid_r && ind_r);
    state_nxt = state_r;
    exec = 1'b0;
    valid_nxt = valid_r;
    two_nxt = two_r;
    ind_nxt = ind_r;
    fop_nxt = fop_r;
    wf_nxt = wf_r;
    ncyc_nxt = ncyc_r;
    cls_nxt = cls_r;
    file_nxt = file_r;
    bit_nxt = bit_r;
    lit_nxt = lit_r;
    ptr_nxt = ptr_r;
    step_nxt = step_r;
    acc_nxt = acc_r;
    if (q_end) begin
      unique case (state_r)
        IDT_ST_RUN: begin
          if (valid_r && ind_r) begin
            state_nxt = IDT_ST_IND;
          end else if (valid_r && two_r) begin
            state_nxt = IDT_ST_FLUSH;
          end else begin
            exec = 1'b1;
          end
        end
        IDT_ST_IND: begin
          if (two_r) begin
            state_nxt = IDT_ST_FLUSH;
          end else begin
            state_nxt = IDT_ST_RUN;
            exec = 1'b1;
          end
        end
        IDT_ST_FLUSH: begin
          state_nxt = IDT_ST_RUN;
          exec = 1'b1;
        end
        default: begin
          state_nxt = IDT_ST_RUN;
        end
      endcase
      // Stall and flush cycles carry no operation
      valid_nxt = exec;
      if (exec) begin
        two_nxt = dec_two;
        ind_nxt = ind_hit;
        fop_nxt = dec_fop;
        wf_nxt = dec_wf;
        ncyc_nxt = 2'h1 + {1'b0, dec_two} + {1'b0, ind_hit};
        cls_nxt = dec_cls;
        file_nxt = dec_file;
        bit_nxt = dec_bit;
        lit_nxt = dec_lit;
        ptr_nxt = dec_ptr;
        step_nxt = dec_step;
        acc_nxt = dec_acc;
      end else if (state_nxt != IDT_ST_IND) begin
        fop_nxt = 1'b0;
        wf_nxt = 1'b0;
      end
    end
    fetch_nxt = (ph_nxt == `IDT_PH_LAST) && take;
    // Registered so the cycle markers leave the block glitch free
    extra_nxt = state_nxt == IDT_ST_IND;
    flush_nxt = state_nxt == IDT_ST_FLUSH;
    cyc_nxt = ph_nxt == `IDT_RST_PH;
    // Read in the second phase whatever the instruction does after
    rd_nxt = ph_nxt == `IDT_PH_READ && valid_nxt && fop_nxt;
    wr_file_nxt = ph_nxt == `IDT_PH_LAST && valid_nxt && wf_nxt;
    wr_acc_nxt = ph_nxt == `IDT_PH_LAST && valid_nxt && fop_nxt &&
      acc_nxt;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= IDT_ST_RUN;
      ph_r <= `IDT_RST_PH;
      valid_r <= `IDT_RST_ZERO;
      two_r <= `IDT_RST_ZERO;
      ind_r <= `IDT_RST_ZERO;
      fop_r <= `IDT_RST_ZERO;
      wf_r <= `IDT_RST_ZERO;
      fetch_r <= `IDT_RST_ZERO;
      cyc_r <= `IDT_RST_ZERO;
      rd_r <= `IDT_RST_ZERO;
      wr_file_r <= `IDT_RST_ZERO;
      wr_acc_r <= `IDT_RST_ZERO;
      ncyc_r <= 2'h0;
      cls_r <= IDT_CLS_BYTE;
      file_r <= '0;
      bit_r <= 3'h0;
      lit_r <= '0;
      ptr_r <= `IDT_RST_ZERO;
      step_r <= IDT_STEP_PREINC;
      acc_r <= `IDT_RST_ZERO;
      extra_r <= `IDT_RST_ZERO;
      flush_r <= `IDT_RST_ZERO;
    end else begin
      state_r <= state_nxt;
      ph_r <= ph_nxt;
      valid_r <= valid_nxt;
      two_r <= two_nxt;
      ind_r <= ind_nxt;
      fop_r <= fop_nxt;
      wf_r <= wf_nxt;
      fetch_r <= fetch_nxt;
      cyc_r <= cyc_nxt;
      rd_r <= rd_nxt;
      wr_file_r <= wr_file_nxt;
      wr_acc_r <= wr_acc_nxt;
      ncyc_r <= ncyc_nxt;
      cls_r <= cls_nxt;
      file_r <= file_nxt;
      bit_r <= bit_nxt;
      lit_r <= lit_nxt;
      ptr_r <= ptr_nxt;
      step_r <= step_nxt;
      acc_r <= acc_nxt;
      extra_r <= extra_nxt;
      flush_r <= flush_nxt;
    end
  end

  always_comb begin
    FETCH_STB = fetch_r;
    PHASE = ph_r;
    CYCLE_START = cyc_r;
    EXTRA_CYCLE = extra_r;
    FLUSH_CYCLE = flush_r;
    INSN_CYCLES = ncyc_r;
    EXEC_VALID = valid_r;
    INSN_CLASS = cls_r;
    FILE_ADDR = file_r;
    BIT_SEL = bit_r;
    LITERAL = lit_r;
    PTR_SEL = ptr_r;
    PTR_STEP = step_r;
    DEST_ACCUM = acc_r;
    RD_FILE = rd_r;
    WR_FILE = wr_file_r;
    WR_ACCUM = wr_acc_r;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_run_cycle;
    (state_r == IDT_ST_RUN)[*4];
  endsequence

  sequence s_enter_plain;
    q_end && exec && !dec_two && !ind_hit;
  endsequence

  AST_CYCLE_LEN: assert property (
    cyc_r |=> !cyc_r [*3] ##1 cyc_r)
    else $error("instruction cycle is not four clocks");

  AST_ONE_CYCLE: assert property (
    s_enter_plain |=> s_run_cycle ##0 valid_r ##1 state_r == IDT_ST_RUN)
    else $error("single-cycle instruction took longer");

  AST_TWO_CYCLE: assert property (
    q_end && exec && dec_two && !ind_hit |=>
      s_run_cycle ##1 (state_r == IDT_ST_FLUSH)[*4]
      ##1 state_r == IDT_ST_RUN)
    else $error("two-cycle instruction timing wrong");

  AST_IND_EXTRA: assert property (
    q_end && exec && ind_hit |=>
      s_run_cycle ##1 (state_r == IDT_ST_IND)[*4])
    else $error("indirect program access added no cycle");

  AST_FLUSH_NOP: assert property (
    state_r != IDT_ST_RUN |-> !valid_r && !wr_file_r && !wr_acc_r)
    else $error("state changed during an extra cycle");

  AST_READ_FIRST: assert property (
    wr_file_r |-> $past(rd_r, 2) && ph_r == `IDT_PH_LAST)
    else $error("file write without the read before it");

  AST_DEST_SPLIT: assert property (
    wr_acc_r |-> acc_r && !wr_file_r)
    else $error("result steered to both targets");

  AST_FETCH_HOLD: assert property (
    state_r == IDT_ST_RUN && valid_r && ind_r && q_end |-> !fetch_r)
    else $error("word taken during an indirect stall");

  AST_CALL_CYCLES: assert property (
    q_end && exec && INSTR_WORD[13:12] == `IDT_TOP_JUMP |=>
      ncyc_r == 2'h2 + {1'b0, ind_r})
    else $error("call or jump cycle count wrong");

endmodule

`default_nettype wire

// ==== pkg/idt_consts.svh ====
// Behaviour
// - Instruction words are 14 bits, self-contained.
// - Classify as byte, bit, or literal/control.
// - Other instructions take exactly one cycle.
// - Call and computed call take two cycles.
// - All three returns take two cycles.
// - Jumps and skip instructions take two cycles.
// - Indirect program-memory pointer adds one cycle.
// - Instruction cycle is four clock periods.
// - File operands are read, modified, stored.
// - File register is read even when only written.
// - File address spans 0x00 through 0x7F.
// - Target bit 0 accumulator, 1 file register.
// - Bit field selects one of eight bits.
// - Pointer field selects pointer 0 or 1.
// - Don't-care bits never change the decode.
// - Two-bit step field picks pre/post inc/dec.
`ifndef IDT_CONSTS_SVH
`define IDT_CONSTS_SVH

// Word layout
`define IDT_WORD_W 14
`define IDT_FILE_W 7
`define IDT_LIT_W 11
`define IDT_DEST_POS 7
`define IDT_BIT_HI 9
`define IDT_BIT_LO 7
`define IDT_NUM_POS 2
`define IDT_KNUM_POS 6
`define IDT_DEREF_HI 6
// Opcode groups in bits 13:12
`define IDT_TOP_FILE 2'h0
`define IDT_TOP_BIT 2'h1
`define IDT_TOP_JUMP 2'h2
`define IDT_TOP_LIT 2'h3
// Byte sub-opcodes in bits 11:8
`define IDT_BOP_MOVE 4'h0
`define IDT_BOP_CLR 4'h1
`define IDT_BOP_DECSKIP 4'hB
`define IDT_BOP_INCSKIP 4'hF
// Control and literal words
`define IDT_CTL_RET 12'h008
`define IDT_CTL_IRET 12'h009
`define IDT_CTL_CJMP 12'h00A
`define IDT_CTL_AJMP 12'h00B
`define IDT_CTL_INDMOV 8'h01
`define IDT_LIT_REL 3'h1
`define IDT_LIT_RETK 2'h1
`define IDT_LIT_KIND 4'hF
// Instruction cycle phases
`define IDT_PH_LAST 2'h3
`define IDT_PH_READ 2'h1
// Reset values
`define IDT_RST_PH 2'h0
`define IDT_RST_ZERO 1'b0

`endif

// ==== pkg/idt_pkg.sv ====
package idt_pkg;

  typedef enum logic [1:0] {
    IDT_CLS_BYTE = 2'h0,
    IDT_CLS_BIT = 2'h1,
    IDT_CLS_LITCTL = 2'h2
  } idt_class_type;

  typedef enum logic [1:0] {
    IDT_ST_RUN = 2'h0,
    IDT_ST_IND = 2'h1,
    IDT_ST_FLUSH = 2'h2
  } idt_state_type;

  typedef enum logic [1:0] {
    IDT_STEP_PREINC = 2'h0,
    IDT_STEP_PREDEC = 2'h1,
    IDT_STEP_POSTINC = 2'h2,
    IDT_STEP_POSTDEC = 2'h3
  } idt_step_type;

endpackage

// ==== logic/idt_field_extract.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "idt_consts.svh"

module idt_field_extract (
  // Instruction
  input wire logic [`IDT_WORD_W-1:0] word,
  // Decoded fields
  output var idt_pkg::idt_class_type cls,
  output logic [`IDT_FILE_W-1:0] file_addr,
  output logic [2:0] bit_sel,
  output logic [`IDT_LIT_W-1:0] literal,
  output logic ptr_sel,
  output var idt_pkg::idt_step_type ptr_step_sel,
  // Decoded behaviour
  output logic file_op,
  output logic dest_accum,
  output logic writes_file,
  output logic two_cycle,
  output logic indirect
);
  import idt_pkg::*;

  logic [1:0] top;
  logic [3:0] bop;

  always_comb begin
    top = word[13:12];
    bop = word[11:8];
    file_addr = word[`IDT_FILE_W-1:0];
    bit_sel = word[`IDT_BIT_HI:`IDT_BIT_LO];
    literal = word[`IDT_LIT_W-1:0];
    ptr_sel = word[`IDT_NUM_POS];
    ptr_step_sel = idt_step_type'(word[1:0]);
    cls = IDT_CLS_LITCTL;
    file_op = 1'b0;
    dest_accum = 1'b0;
    writes_file = 1'b0;
    two_cycle = 1'b0;
    indirect = 1'b0;
    if (top == `IDT_TOP_FILE && word[11:7] != 5'h00) begin
      cls = IDT_CLS_BYTE;
      file_op = 1'b1;
      dest_accum = ~word[`IDT_DEST_POS];
      if (bop == `IDT_BOP_MOVE) begin
        dest_accum = 1'b0;
      end
      // Accumulator clear: low bits are don't-care
      if (bop == `IDT_BOP_CLR && !word[`IDT_DEST_POS]) begin
        file_op = 1'b0;
      end
      writes_file = file_op & ~dest_accum;
      two_cycle = (bop == `IDT_BOP_DECSKIP) ||
        (bop == `IDT_BOP_INCSKIP);
    end else if (top == `IDT_TOP_BIT) begin
      cls = IDT_CLS_BIT;
      file_op = 1'b1;
      writes_file = ~word[11];
      two_cycle = word[11];
    end else if (top == `IDT_TOP_JUMP) begin
      two_cycle = 1'b1;
    end else if (top == `IDT_TOP_LIT) begin
      // Return-with-literal ignores bits 9:8
      two_cycle = (word[11:9] == `IDT_LIT_REL) ||
        (word[11:10] == `IDT_LIT_RETK);
      if (bop == `IDT_LIT_KIND) begin
        indirect = 1'b1;
        ptr_sel = word[`IDT_KNUM_POS];
      end
    end else begin
      two_cycle = (word[11:0] == `IDT_CTL_RET) ||
        (word[11:0] == `IDT_CTL_IRET) ||
        (word[11:0] == `IDT_CTL_CJMP) ||
        (word[11:0] == `IDT_CTL_AJMP);
      indirect = word[11:4] == `IDT_CTL_INDMOV;
    end
    // Deref registers sit at the two lowest file addresses
    if (file_op && word[`IDT_DEREF_HI:1] == 6'h00) begin
      indirect = 1'b1;
      ptr_sel = word[0];
    end
  end

endmodule

`default_nettype wire

// ==== bench/idt_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "idt_consts.svh"

module testbench;
  import idt_pkg::*;
  logic CLK, RST_N, FETCH_STB, CYCLE_START, EXTRA_CYCLE, FLUSH_CYCLE;
  logic EXEC_VALID, PTR_SEL, DEST_ACCUM, RD_FILE, WR_FILE, WR_ACCUM;
  logic [`IDT_WORD_W-1:0] INSTR_WORD;
  logic [1:0] PTR_PROG, PHASE, INSN_CYCLES;
  logic [`IDT_FILE_W-1:0] FILE_ADDR;
  logic [2:0] BIT_SEL;
  logic [`IDT_LIT_W-1:0] LITERAL;
  idt_class_type INSN_CLASS;
  idt_step_type PTR_STEP;
  int failures, cmp_count;
  // Fields stand only until the trailing no-op executes, so keep a copy
  logic [`IDT_FILE_W-1:0] seen_file;
  logic [2:0] seen_bit;
  logic [`IDT_LIT_W-1:0] seen_lit;
  logic [1:0] seen_step;
  logic seen_ptr, seen_acc;

  idt_core DUT (.CLK(CLK), .RST_N(RST_N), .INSTR_WORD(INSTR_WORD),
    .PTR_PROG(PTR_PROG), .FETCH_STB(FETCH_STB), .PHASE(PHASE),
    .CYCLE_START(CYCLE_START), .EXTRA_CYCLE(EXTRA_CYCLE),
    .FLUSH_CYCLE(FLUSH_CYCLE), .INSN_CYCLES(INSN_CYCLES),
    .EXEC_VALID(EXEC_VALID), .INSN_CLASS(INSN_CLASS),
    .FILE_ADDR(FILE_ADDR), .BIT_SEL(BIT_SEL), .LITERAL(LITERAL),
    .PTR_SEL(PTR_SEL), .PTR_STEP(PTR_STEP), .DEST_ACCUM(DEST_ACCUM),
    .RD_FILE(RD_FILE), .WR_FILE(WR_FILE), .WR_ACCUM(WR_ACCUM));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic final_report();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Present a word in the fetch phase; a no-op follows so a held word
  // cannot be executed twice
  task automatic issue(input logic [13:0] w, input logic [1:0] p);
    int n;
    n = 0;
    while (FETCH_STB !== 1'b1) begin
      @(negedge CLK);
      n++;
      if (n > 40) begin
        failures++;
        final_report();
      end
    end
    INSTR_WORD = w;
    PTR_PROG = p;
    @(negedge CLK);
    INSTR_WORD = 14'h0000;
  endtask

  // Run one instruction; mk bit0 checks the read, bit1 the writes
  task automatic run(input logic [13:0] w, input logic [1:0] p,
      input logic [1:0] cls, input logic [1:0] cyc, input logic ext,
      input logic [1:0] mk, input logic rd, input logic [1:0] wr);
    issue(w, p);
    seen_file = FILE_ADDR;
    seen_bit = BIT_SEL;
    seen_lit = LITERAL;
    seen_step = PTR_STEP;
    seen_ptr = PTR_SEL;
    seen_acc = DEST_ACCUM;
    check(EXEC_VALID, 16'h1);
    check(CYCLE_START, 16'h1);
    check(INSN_CLASS, cls);
    check(INSN_CYCLES, cyc);
    for (int i = 0; i < 4; i++) begin
      check(PHASE, i[1:0]);
      if (i == 1 && mk[0]) check(RD_FILE, rd);
      if (i == 3 && mk[1]) check({WR_FILE, WR_ACCUM}, wr);
      if (i == 3) check(FETCH_STB, !ext);
      @(negedge CLK);
    end
    for (int c = 1; c < cyc; c++) begin
      for (int i = 0; i < 4; i++) begin
        check({EXEC_VALID, RD_FILE, WR_FILE, WR_ACCUM}, 16'h0);
        check({EXTRA_CYCLE, FLUSH_CYCLE},
          (c == 1 && ext) ? 2'h2 : 2'h1);
        @(negedge CLK);
      end
    end
  endtask

  task automatic t_byte();
    run(14'h00FF, 2'h0, 2'h0, 2'h1, 1'b0, 2'h3, 1'b1, 2'h2);
    check(seen_file, 16'h7F);
    check(seen_acc, 16'h0);
    run(14'h0705, 2'h0, 2'h0, 2'h1, 1'b0, 2'h3, 1'b1, 2'h1);
    check(seen_file, 16'h05);
    check(seen_acc, 16'h1);
    run(14'h0B85, 2'h0, 2'h0, 2'h2, 1'b0, 2'h3, 1'b1, 2'h2);
  endtask

  task automatic t_bit();
    run(14'h12A0, 2'h0, 2'h1, 2'h1, 1'b0, 2'h1, 1'b1, 2'h0);
    check(seen_bit, 16'h5);
    run(14'h1BFF, 2'h0, 2'h1, 2'h2, 1'b0, 2'h1, 1'b1, 2'h0);
    check(seen_bit, 16'h7);
  endtask

  // Returns, computed call, offset jump, call and jumps
  task automatic t_ctl();
    logic [13:0] w[6] = '{14'h0008, 14'h0009, 14'h000A, 14'h000B,
      14'h2555, 14'h3255};
    foreach (w[k]) begin
      run(w[k], 2'h0, 2'h2, 2'h2, 1'b0, 2'h3, 1'b0, 2'h0);
    end
    check(seen_lit[8:0], 16'h055);
    run(14'h3400 | 14'h5A, 2'h0, 2'h2, 2'h2, 1'b0, 2'h3, 1'b0, 2'h0);
    check(seen_lit[7:0], 16'h5A);
    run(14'h3700 | 14'h5A, 2'h0, 2'h2, 2'h2, 1'b0, 2'h3, 1'b0, 2'h0);
    check(seen_lit[7:0], 16'h5A);
  endtask

  // Pointer 1 aims at program memory, pointer 0 at data, except one run with pointer 0 at program memory
  task automatic t_ind();
    run(14'h0B81, 2'h2, 2'h0, 2'h3, 1'b1, 2'h3, 1'b1, 2'h2);
    check(seen_ptr, 16'h1);
    run(14'h0780, 2'h2, 2'h0, 2'h1, 1'b0, 2'h3, 1'b1, 2'h2);
    check(seen_ptr, 16'h0);
    run(14'h0780, 2'h1, 2'h0, 2'h2, 1'b1, 2'h3, 1'b1, 2'h2);
    run(14'h3F45, 2'h2, 2'h2, 2'h2, 1'b1, 2'h0, 1'b0, 2'h0);
    check(seen_ptr, 16'h1);
  endtask

  task automatic t_step();
    for (int m = 0; m < 4; m++) begin
      run(14'h0014 + m[13:0], 2'h0, 2'h2, 2'h1, 1'b0, 2'h0, 1'b0, 2'h0);
      check(seen_step, m[1:0]);
      check(seen_ptr, 16'h1);
    end
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    RST_N = 1'b0;
    INSTR_WORD = 14'h0000;
    PTR_PROG = 2'h0;
    repeat (10) @(negedge CLK);
    check({FETCH_STB, EXEC_VALID, RD_FILE, WR_FILE, PHASE}, 16'h0);
    RST_N = 1'b1;
    t_byte();
    t_bit();
    t_ctl();
    t_ind();
    t_step();
    final_report();
  end
endmodule

`default_nettype wire
